// ### rtl/core_params.svh
`ifndef CORE_PARAMS_SVH
`define CORE_PARAMS_SVH

// data and instruction widths
`define DATA_W 8
`define INSTR_W 16

// instruction word layout
`define OP_MSB 15
`define OP_LSB 11
`define DEST_BIT 10
`define CARRY_BIT 9
`define IMM_BIT 8
`define BSEL_MSB 10
`define BSEL_LSB 8
`define FIELD_MSB 7
`define FIELD_LSB 0
`define TARGET_W 11

// program counter and stack sizing
`define PC_WIDTH_DEF 11
`define PC_WIDTH_MIN 9
`define STACK_DEPTH_DEF 8

// data address that maps onto the program counter low byte
`define PC_LOW_ADDR 8'h06

// phases of one instruction cycle
`define CLOCKS_PER_CYCLE 4
`define PH_ADDR 2'h0
`define PH_FETCH 2'h1
`define PH_DATA 2'h2
`define PH_EXEC 2'h3

// small constants met by the datapath
`define DATA_ZERO 8'h00
`define ONE_STEP 8'h01
`define LOW_BIT_MASK 8'h01
`define SKIP_STEP 2'h2

`endif

// ### rtl/core_pkg.sv
`default_nettype none

package core_pkg;

  // instruction classes, in the order of their 5-bit codes
  typedef enum logic [4:0] {
    op_nop, op_transfer_to_acc, op_transfer_to_mem, op_add, op_sub,
    op_and, op_or, op_xor, op_complement, op_add_one, op_subtract_one,
    op_rotate, op_bit_set, op_bit_clear, op_skip_zero, op_skip_bit_set,
    op_skip_bit_clear, op_unconditional_jump, op_call,
    op_subroutine_exit, op_table_read, op_halt, op_watchdog_clear,
    op_clear
  } opcode_type;

  typedef enum logic [3:0] {
    alu_pass, alu_add, alu_sub, alu_and, alu_or, alu_xor,
    alu_complement, alu_rotate_right, alu_rotate_left,
    alu_rotate_right_via_carry, alu_rotate_left_via_carry
  } alu_op_type;

  typedef struct packed {
    logic zero;
    logic carry;
    logic half_carry_flag;
    logic signed_range_flag;
  } flags_type;

endpackage

`default_nettype wire

// ### rtl/alu_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "core_params.svh"

// operands in, result and adder flags out
interface alu_if;
  import core_pkg::*;
  alu_op_type op;
  logic [`DATA_W-1:0] a;
  logic [`DATA_W-1:0] b;
  logic cin;
  logic [`DATA_W-1:0] result;
  logic carry_out;
  logic half_out;
  logic range_out;
  modport core (output op, output a, output b, output cin,
    input result, input carry_out, input half_out, input range_out);
  modport alu (input op, input a, input b, input cin,
    output result, output carry_out, output half_out, output range_out);
endinterface

`default_nettype wire

// ### rtl/alu_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "core_params.svh"

module alu_unit (
  alu_if.alu link
);
  import core_pkg::*;

  logic is_sub;
  logic [`DATA_W-1:0] b_eff;
  logic [`DATA_W:0] sum;
  logic [4:0] half_sum;

  // subtract adds the inverted operand, so carry out means no borrow
  assign is_sub = link.op == alu_sub;
  assign b_eff = is_sub ? ~link.b : link.b;
  assign sum = {1'b0, link.a} + {1'b0, b_eff} + {8'h00, link.cin};
  assign half_sum = {1'b0, link.a[3:0]} + {1'b0, b_eff[3:0]}
    + {4'h0, link.cin};

  // half carry from bit 3, signed range from like-signed operands
  assign link.half_out = half_sum[4];
  assign link.range_out = (link.a[7] == b_eff[7]) && (sum[7] != link.a[7]);

  // result select; rotates via carry replace the carry out
  always_comb begin
    link.result = link.b;
    link.carry_out = sum[`DATA_W];
    case (link.op)
      alu_add, alu_sub: link.result = sum[`DATA_W-1:0];
      alu_and: link.result = link.a & link.b;
      alu_or: link.result = link.a | link.b;
      alu_xor: link.result = link.a ^ link.b;
      alu_complement: link.result = ~link.a;
      alu_rotate_right: link.result = {link.a[0], link.a[7:1]};
      alu_rotate_left: link.result = {link.a[6:0], link.a[7]};
      alu_rotate_right_via_carry: begin
        link.result = {link.cin, link.a[7:1]};
        link.carry_out = link.a[0];
      end
      alu_rotate_left_via_carry: begin
        link.result = {link.a[6:0], link.cin};
        link.carry_out = link.a[7];
      end
      default: link.result = link.b;
    endcase
  end

endmodule // alu_unit

`default_nettype wire

// ### rtl/instruction_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "core_params.svh"

// How it works
// - ordinary instructions finish in one cycle
// - jump, call, table read take two cycles
// - one instruction cycle is four clocks
// - program counter low writes jump, cost extra
// - taken skip costs one extra cycle
// - three transfers: to acc, to memory, immediate
// - add carries past 255, subtract borrows
// - add or subtract one, memory or acc
// - logic results of zero set zero flag
// - rotate one bit, via-carry variants use carry
// - call saves return, exit resumes after call
// - jump loads target, saves nothing
// - conditional skips test byte or single bit
// - bit set or clear touches one bit
// - table read moves program words to registers
// - halt powers down, separate watchdog clear
// - two-operand work always goes through acc
// - bit select spans positions 0 to 7
// - add updates zero, carry, half, range flags
module instruction_unit #(
  parameter int PC_WIDTH = `PC_WIDTH_DEF,
  parameter int STACK_DEPTH = `STACK_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`INSTR_W-1:0] pm_data,
  input wire logic [`DATA_W-1:0] dm_rdata,
  input wire logic wake,
  output logic [PC_WIDTH-1:0] pm_addr,
  output logic [`DATA_W-1:0] dm_addr,
  output logic [`DATA_W-1:0] dm_wdata,
  output logic dm_we,
  output logic [`DATA_W-1:0] acc,
  output core_pkg::flags_type flags,
  output logic [`DATA_W-1:0] table_high,
  output logic powered_down,
  output logic watchdog_clear,
  output logic int_enable,
  output logic retired
);
  import core_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH);

  // refuse sizes the instruction layout and stack cannot serve
  generate
    if (PC_WIDTH < `PC_WIDTH_MIN || PC_WIDTH > `TARGET_W) begin : g_bad_pc
      $error("PC_WIDTH outside the jump target field");
    end
    if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_bad_sp
      $error("STACK_DEPTH must be a power of two, at least 2");
    end
    if (`CLOCKS_PER_CYCLE != 4) begin : g_bad_phase
      $error("phase counter is two bits wide");
    end
  endgenerate

  alu_if alu_link ();

  logic [1:0] phase;
  logic [`INSTR_W-1:0] ir;
  logic [`INSTR_W-1:0] table_word;
  logic [PC_WIDTH-1:0] pc;
  logic bubble;
  logic table_pending;
  logic [PC_WIDTH-1:0] stack [STACK_DEPTH];
  logic [SP_W-1:0] sp;

  opcode_type op;
  logic [`DATA_W-1:0] field8;
  logic [`DATA_W-1:0] operand;
  logic [`DATA_W-1:0] b_src;
  logic [`DATA_W-1:0] bit_mask;
  logic [`DATA_W-1:0] result;
  logic [2:0] bsel;
  logic to_acc;
  logic use_imm;
  logic with_carry;
  logic is_pc_low;
  logic ph_last;
  logic run_step;
  logic is_two_op;
  logic is_step;
  logic computes;
  logic dest_acc;
  logic dest_mem;
  logic pc_low_write;
  logic bit_is_set;
  logic skip_taken;
  logic two_cycle;
  logic do_push;
  logic do_pop;
  logic [PC_WIDTH-1:0] pc_inc;
  logic [PC_WIDTH-1:0] target;
  logic [PC_WIDTH-1:0] table_addr;
  logic [PC_WIDTH-1:0] next_pc;
  flags_type next_flags;

  // map an instruction onto the datapath operation
  function automatic alu_op_type pick_alu(opcode_type code, logic left,
                                          logic thru);
    case (code)
      op_add, op_add_one: pick_alu = alu_add;
      op_sub, op_subtract_one: pick_alu = alu_sub;
      op_and: pick_alu = alu_and;
      op_or: pick_alu = alu_or;
      op_xor: pick_alu = alu_xor;
      op_complement: pick_alu = alu_complement;
      op_rotate: pick_alu = left
        ? (thru ? alu_rotate_left_via_carry : alu_rotate_left)
        : (thru ? alu_rotate_right_via_carry : alu_rotate_right);
      default: pick_alu = alu_pass;
    endcase
  endfunction

  // instruction fields; unused codes fall through as no-ops
  assign op = opcode_type'(ir[`OP_MSB:`OP_LSB]);
  assign field8 = ir[`FIELD_MSB:`FIELD_LSB];
  assign to_acc = ir[`DEST_BIT];
  assign use_imm = ir[`IMM_BIT];
  assign with_carry = ir[`CARRY_BIT];
  assign bsel = ir[`BSEL_MSB:`BSEL_LSB];
  assign target = ir[PC_WIDTH-1:0];

  // the program counter low byte reads as a data location
  assign is_pc_low = field8 == `PC_LOW_ADDR;
  assign operand = is_pc_low ? pc[`DATA_W-1:0] : dm_rdata;
  assign b_src = use_imm ? field8 : operand;
  assign bit_mask = `LOW_BIT_MASK << bsel;

  // execution happens on the last phase of a first cycle only
  assign ph_last = phase == `PH_EXEC;
  assign run_step = ph_last && !bubble && !powered_down;

  // operand routing: two-operand forms always take acc as a
  assign is_two_op = op inside {op_add, op_sub, op_and, op_or,
    op_xor};
  assign is_step = op inside {op_add_one, op_subtract_one};
  assign computes = is_two_op || is_step || op == op_complement
    || op == op_rotate;
  assign alu_link.op = pick_alu(op, use_imm, with_carry);
  assign alu_link.a = is_two_op ? acc : operand;
  assign alu_link.b = is_step ? `ONE_STEP : b_src;
  // plain subtract and decrement inject 1 to finish the inversion
  assign alu_link.cin = (with_carry && !is_step) ? flags.carry
    : (op == op_sub || op == op_subtract_one);

  // result select: bit forms rewrite one bit of the fetched byte
  assign result = (op == op_bit_set) ? (operand | bit_mask)
    : (op == op_bit_clear) ? (operand & ~bit_mask)
    : (op == op_transfer_to_mem) ? acc
    : (op == op_clear) ? `DATA_ZERO
    : alu_link.result;

  // destinations; immediate two-operand forms always land in acc
  assign dest_acc = op == op_transfer_to_acc
    || (computes && (to_acc || (is_two_op && use_imm)));
  assign dest_mem = (computes && !dest_acc)
    || op inside {op_transfer_to_mem, op_bit_set, op_bit_clear, op_clear};
  assign pc_low_write = dest_mem && is_pc_low;

  // conditional skips look at a whole byte or at one bit
  assign bit_is_set = |(operand & bit_mask);
  assign skip_taken = (op == op_skip_zero && operand == `DATA_ZERO)
    || (op == op_skip_bit_set && bit_is_set)
    || (op == op_skip_bit_clear && !bit_is_set);

  // which instructions earn a second cycle
  assign two_cycle = op inside {op_unconditional_jump, op_call,
    op_subroutine_exit, op_table_read} || pc_low_write || skip_taken;

  // stack movement for call and both exit forms
  assign do_push = run_step && op == op_call;
  assign do_pop = run_step && op == op_subroutine_exit;

  // tables live in the top page, indexed by acc
  assign table_addr = {{(PC_WIDTH - `DATA_W){1'b1}}, acc};

  // next program counter; a taken skip steps over one word
  assign pc_inc = pc + 1'b1;
  assign next_pc = (op == op_unconditional_jump || op == op_call) ? target
    : (op == op_subroutine_exit) ? stack[sp - 1'b1]
    : pc_low_write ? {pc[PC_WIDTH-1:`DATA_W], result}
    : skip_taken ? pc + PC_WIDTH'(`SKIP_STEP)
    : pc_inc;

  // flag updates per class; moves and bit forms leave flags alone
  always_comb begin
    next_flags = flags;
    if (computes && op != op_rotate) begin
      next_flags.zero = result == `DATA_ZERO;
    end
    if (op == op_add || op == op_sub) begin
      next_flags.carry = alu_link.carry_out;
      next_flags.half_carry_flag = alu_link.half_out;
      next_flags.signed_range_flag = alu_link.range_out;
    end
    if (op == op_rotate && with_carry) begin
      next_flags.carry = alu_link.carry_out;
    end
  end

  alu_unit i_alu_unit (
    .link(alu_link.alu)
  );

  // free-running phase counter; it only rests while powered down
  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= `PH_ADDR;
    end else if (!powered_down) begin
      phase <= phase + 1'b1;
    end
  end

  // program address: current pc, or the table word during a table-read bubble
  always_ff @(posedge clk) begin
    if (reset) begin
      pm_addr <= '0;
    end else if (phase == `PH_ADDR && !powered_down) begin
      pm_addr <= (bubble && table_pending) ? table_addr : pc;
    end
  end

  // capture the word; a bubble keeps ir so [m] is still known
  always_ff @(posedge clk) begin
    if (reset) begin
      ir <= '0;
      table_word <= '0;
    end else if (phase == `PH_FETCH && !powered_down) begin
      if (bubble) begin
        table_word <= pm_data;
      end else begin
        ir <= pm_data;
      end
    end
  end

  // data address is the operand field of the freshly fetched word
  always_ff @(posedge clk) begin
    if (reset) begin
      dm_addr <= '0;
    end else if (phase == `PH_DATA && !bubble && !powered_down) begin
      dm_addr <= field8;
    end
  end

  // program counter; skip the update on a bubble
  always_ff @(posedge clk) begin
    if (reset) begin
      pc <= '0;
    end else if (run_step) begin
      pc <= next_pc;
    end
  end

  // second-cycle bookkeeping: a whole extra cycle, then resume
  always_ff @(posedge clk) begin
    if (reset) begin
      bubble <= 1'b0;
      table_pending <= 1'b0;
    end else if (ph_last && bubble) begin
      bubble <= 1'b0;
      table_pending <= 1'b0;
    end else if (run_step) begin
      bubble <= two_cycle;
      table_pending <= op == op_table_read;
    end
  end

  // return stack; no overflow guard, it simply wraps
  always_ff @(posedge clk) begin
    if (reset) begin
      sp <= '0;
    end else if (do_push) begin
      sp <= sp + 1'b1;
    end else if (do_pop) begin
      sp <= sp - 1'b1;
    end
  end

  // stack storage needs no reset, sp marks what is valid
  always_ff @(posedge clk) begin
    if (do_push) begin
      stack[sp] <= pc_inc;
    end
  end

  // accumulator and flags
  always_ff @(posedge clk) begin
    if (reset) begin
      acc <= '0;
      flags <= '0;
    end else if (run_step) begin
      flags <= next_flags;
      if (dest_acc) begin
        acc <= result;
      end
    end
  end

  // memory write strobe is one clock, in phase 0 of the next cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      dm_we <= 1'b0;
      dm_wdata <= '0;
      table_high <= '0;
    end else if (ph_last && bubble && table_pending) begin
      dm_we <= 1'b1;
      dm_wdata <= table_word[`DATA_W-1:0];
      table_high <= table_word[`INSTR_W-1:`DATA_W];
    end else if (run_step && dest_mem && !is_pc_low) begin
      dm_we <= 1'b1;
      dm_wdata <= result;
    end else begin
      dm_we <= 1'b0;
    end
  end

  // power-down; halt wins if wake arrives the same edge
  always_ff @(posedge clk) begin
    if (reset) begin
      powered_down <= 1'b0;
    end else if (run_step && op == op_halt) begin
      powered_down <= 1'b1;
    end else if (wake) begin
      powered_down <= 1'b0;
    end
  end

  // watchdog service is a single-clock pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      watchdog_clear <= 1'b0;
    end else begin
      watchdog_clear <= run_step && op == op_watchdog_clear;
    end
  end

  // interrupt exit re-arms interrupts; only reset clears it
  always_ff @(posedge clk) begin
    if (reset) begin
      int_enable <= 1'b0;
    end else if (do_pop && to_acc) begin
      int_enable <= 1'b1;
    end
  end

  // one pulse per executed instruction, handy for cycle counting
  always_ff @(posedge clk) begin
    if (reset) begin
      retired <= 1'b0;
    end else begin
      retired <= run_step;
    end
  end

endmodule // instruction_unit

`default_nettype wire

// ### bench/instruction_unit_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "core_params.svh"

module instruction_unit_props #(
  parameter int PC_WIDTH = `PC_WIDTH_DEF,
  parameter int STACK_DEPTH = `STACK_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`INSTR_W-1:0] pm_data,
  input wire logic [`DATA_W-1:0] dm_rdata,
  input wire logic wake,
  input wire logic [PC_WIDTH-1:0] pm_addr,
  input wire logic [`DATA_W-1:0] dm_addr,
  input wire logic [`DATA_W-1:0] dm_wdata,
  input wire logic dm_we,
  input wire logic [`DATA_W-1:0] acc,
  input wire core_pkg::flags_type flags,
  input wire logic [`DATA_W-1:0] table_high,
  input wire logic powered_down,
  input wire logic watchdog_clear,
  input wire logic int_enable,
  input wire logic retired
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // pacing: nothing retires or writes faster than one cycle of four clocks
  property p_retire_gap;
    retired |=> !retired [*3];
  endproperty
  a_retire_gap: assert property (p_retire_gap)
    else $error("fast retire");
  property p_pm_hold;
    $changed(pm_addr) |=> $stable(pm_addr) [*3];
  endproperty
  a_pm_hold: assert property (p_pm_hold)
    else $error("pm_addr moved");
  property p_we_gap;
    dm_we |=> !dm_we [*3];
  endproperty
  a_we_gap: assert property (p_we_gap) else $error("double write");
  // results land only together with a retire pulse
  property p_state_on_retire;
    ($changed(acc) || $changed(flags)) |-> retired;
  endproperty
  a_state_on_retire: assert property (p_state_on_retire)
    else $error("stray");
  // the pc low byte is not a memory cell, so no strobe for it
  property p_we_not_pc;
    dm_we |-> (dm_addr != `PC_LOW_ADDR);
  endproperty
  a_we_not_pc: assert property (p_we_not_pc) else $error("pcl write");
  property p_wd_pulse;
    watchdog_clear |=> !watchdog_clear;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("wd level");
  property p_int_sticky;
    int_enable |=> int_enable;
  endproperty
  a_int_sticky: assert property (p_int_sticky)
    else $error("int dropped");
  // asleep without wake means a frozen core
  property p_sleep_frozen;
    (powered_down && !wake) |=> (!retired && !dm_we && $stable(pm_addr));
  endproperty
  a_sleep_frozen: assert property (p_sleep_frozen)
    else $error("awake");
endmodule // instruction_unit_props

bind instruction_unit instruction_unit_props #(.PC_WIDTH(PC_WIDTH),
  .STACK_DEPTH(STACK_DEPTH)) i_instruction_unit_props (.clk(clk),
  .reset(reset), .pm_data(pm_data), .dm_rdata(dm_rdata), .wake(wake),
  .pm_addr(pm_addr), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we),
  .acc(acc), .flags(flags), .table_high(table_high),
  .powered_down(powered_down), .watchdog_clear(watchdog_clear),
  .int_enable(int_enable), .retired(retired));

`default_nettype wire

// ### bench/mem_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "core_params.svh"

module mem_model (
  input wire logic clk,
  input wire logic [10:0] pm_addr,
  output logic [`INSTR_W-1:0] pm_data,
  input wire logic [`DATA_W-1:0] dm_addr,
  output logic [`DATA_W-1:0] dm_rdata,
  input wire logic [`DATA_W-1:0] dm_wdata,
  input wire logic dm_we
);
  logic [`INSTR_W-1:0] prog [0:2047];
  logic [`DATA_W-1:0] data [0:255];
  // zero-wait reads; table words live in the same array
  assign pm_data = prog[pm_addr];
  assign dm_rdata = data[dm_addr];
  // whole-byte writes only, bit merging stays in the core
  always @(posedge clk) begin
    if (dm_we === 1'b1) begin
      data[dm_addr] <= dm_wdata;
    end
  end
endmodule // mem_model

`default_nettype wire

// ### bench/instruction_timing_and_ops_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "core_params.svh"

module instruction_timing_and_ops_tb;
  import core_pkg::*;
  logic clk;
  logic reset;
  logic wake;
  logic [`INSTR_W-1:0] pm_data;
  logic [`DATA_W-1:0] dm_rdata;
  logic [10:0] pm_addr;
  logic [`DATA_W-1:0] dm_addr;
  logic [`DATA_W-1:0] dm_wdata;
  logic dm_we;
  logic [`DATA_W-1:0] acc;
  flags_type flags;
  logic [`DATA_W-1:0] table_high;
  logic powered_down;
  logic watchdog_clear;
  logic int_enable;
  logic retired;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int wd_seen = 0;

  instruction_unit i_instruction_unit (.clk(clk), .reset(reset),
    .pm_data(pm_data), .dm_rdata(dm_rdata), .wake(wake), .pm_addr(pm_addr),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .acc(acc),
    .flags(flags), .table_high(table_high), .powered_down(powered_down),
    .watchdog_clear(watchdog_clear), .int_enable(int_enable),
    .retired(retired));
  mem_model i_mem_model (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data),
    .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata),
    .dm_we(dm_we));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // cycle stamp and watchdog pulse tally
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (watchdog_clear === 1'b1) wd_seen <= wd_seen + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
      input string what);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] enc(input opcode_type op,
      input logic [2:0] mid, input logic [7:0] f);
    return {op, mid, f};
  endfunction
  task automatic put(input int a, input logic [15:0] w);
    i_mem_model.prog[a] = w;
  endtask
  // memory is reloaded only under reset, so no old program can write
  task automatic hold_reset();
    @(posedge clk);
    #1 reset = 1'b1;
    for (int a = 0; a < 2048; a++) i_mem_model.prog[a] = 16'h0000;
  endtask
  task automatic release_reset();
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
  endtask
  // bounded wait; a lost retire counts as a mismatch
  task automatic wait_ret(output int t);
    int n;
    n = 0;
    t = -1;
    while (n < 40 && t < 0) begin
      @(posedge clk);
      #1;
      n++;
      if (retired === 1'b1) t = cyc;
    end
    if (t < 0) check(8'h00, 8'h01, "no retire");
  endtask

  task automatic test_arith();
    int t0;
    int t;
    hold_reset();
    i_mem_model.data[8'h20] = 8'h55;
    put(0, enc(op_transfer_to_acc, 3'h1, 8'hf0));
    put(1, enc(op_add, 3'h1, 8'h10));
    put(2, enc(op_transfer_to_mem, 3'h0, 8'h20));
    put(3, enc(op_sub, 3'h1, 8'h01));
    put(4, enc(op_add, 3'h3, 8'h80));
    put(5, enc(op_add, 3'h3, 8'h08));
    release_reset();
    wait_ret(t0);
    check(acc, 8'hf0, "imm move");
    wait_ret(t);
    check(acc, 8'h00, "add wrap");
    check({4'h0, flags}, 8'h0c, "add flags");
    wait_ret(t);
    wait_ret(t);
    check(acc, 8'hff, "sub value");
    check({6'h00, flags.zero, flags.carry}, 8'h00, "borrow");
    check(i_mem_model.data[8'h20], 8'h00, "acc to mem");
    check(8'(t - t0), 8'h0c, "single cycles");
    wait_ret(t);
    check(acc, 8'h7f, "carry add value");
    check({4'h0, flags}, 8'h05, "signed range");
    wait_ret(t);
    check(acc, 8'h88, "carry in");
    check({4'h0, flags}, 8'h03, "half carry");
    $display("test arith done");
  endtask

  task automatic test_step_bits();
    int t;
    hold_reset();
    i_mem_model.data[8'h30] = 8'h0f;
    i_mem_model.data[8'h31] = 8'h5a;
    put(0, enc(op_add_one, 3'h0, 8'h30));
    put(1, enc(op_subtract_one, 3'h4, 8'h30));
    put(2, enc(op_and, 3'h1, 8'hf0));
    put(3, enc(op_bit_set, 3'h7, 8'h30));
    put(4, enc(op_bit_clear, 3'h4, 8'h30));
    put(5, enc(op_complement, 3'h4, 8'h31));
    put(6, enc(op_or, 3'h0, 8'h31));
    put(7, enc(op_xor, 3'h1, 8'ha5));
    put(8, enc(op_transfer_to_acc, 3'h0, 8'h31));
    release_reset();
    wait_ret(t);
    wait_ret(t);
    check(acc, 8'h0f, "step to acc");
    check(i_mem_model.data[8'h30], 8'h10, "step in place");
    wait_ret(t);
    check(acc, 8'h00, "and value");
    check({7'h00, flags.zero}, 8'h01, "and zero");
    repeat (3) wait_ret(t);
    check(acc, 8'ha5, "complement");
    check({7'h00, flags.zero}, 8'h00, "nonzero");
    check(i_mem_model.data[8'h30], 8'h80, "bit ops");
    check(i_mem_model.data[8'h31], 8'h5a, "acc variant");
    repeat (2) wait_ret(t);
    check(acc, 8'h00, "xor value");
    check({7'h00, flags.zero}, 8'h01, "xor zero");
    wait_ret(t);
    check(acc, 8'hff, "or to memory");
    check({7'h00, flags.zero}, 8'h01, "move keeps flags");
    $display("test step and bits done");
  endtask

  task automatic test_rotate();
    int t;
    hold_reset();
    i_mem_model.data[8'h40] = 8'h81;
    put(0, enc(op_rotate, 3'h4, 8'h40));
    put(1, enc(op_rotate, 3'h7, 8'h40));
    put(2, enc(op_rotate, 3'h2, 8'h40));
    put(3, enc(op_rotate, 3'h5, 8'h40));
    release_reset();
    wait_ret(t);
    check(acc, 8'hc0, "rotate right");
    wait_ret(t);
    check({acc[6:0], flags.carry}, 8'h05, "left via carry");
    wait_ret(t);
    wait_ret(t);
    check(i_mem_model.data[8'h40], 8'hc0, "right via carry");
    check({acc[6:0], flags.carry}, 8'h03, "rotate left");
    $display("test rotate done");
  endtask

  task automatic test_flow();
    int tr [0:8];
    int gap [0:7] = '{8, 8, 4, 8, 8, 4, 8, 8};
    hold_reset();
    i_mem_model.data[8'h50] = 8'h00;
    i_mem_model.data[8'h51] = 8'hfe;
    put(0, enc(op_unconditional_jump, 3'h0, 8'h04));
    put(4, enc(op_call, 3'h0, 8'h0a));
    put(10, enc(op_transfer_to_acc, 3'h1, 8'h03));
    put(11, enc(op_subroutine_exit, 3'h4, 8'h00));
    put(5, enc(op_skip_zero, 3'h0, 8'h50));
    put(6, enc(op_transfer_to_acc, 3'h1, 8'hee));
    put(7, enc(op_skip_bit_set, 3'h0, 8'h51));
    put(8, enc(op_table_read, 3'h0, 8'h52));
    put(9, enc(op_transfer_to_mem, 3'h0, 8'h06));
    put(3, enc(op_transfer_to_acc, 3'h1, 8'h77));
    put(11'h703, 16'ha55a);
    release_reset();
    for (int i = 0; i < 9; i++) begin
      wait_ret(tr[i]);
      if (i == 5) check(acc, 8'h03, "skipped word");
    end
    for (int i = 0; i < 8; i++) begin
      check(8'(tr[i + 1] - tr[i]), 8'(gap[i]), "cycle count");
    end
    check(acc, 8'h77, "pcl jump");
    check(table_high, 8'ha5, "table high");
    check(i_mem_model.data[8'h52], 8'h5a, "table low");
    check({7'h00, int_enable}, 8'h01, "int exit");
    $display("test flow done");
  endtask

  task automatic test_halt();
    int t;
    int wd0;
    hold_reset();
    put(0, enc(op_watchdog_clear, 3'h0, 8'h00));
    put(1, enc(op_halt, 3'h0, 8'h00));
    put(2, enc(op_transfer_to_acc, 3'h1, 8'h5c));
    wd0 = wd_seen;
    release_reset();
    wait_ret(t);
    wait_ret(t);
    repeat (20) @(posedge clk);
    #1;
    check({7'h00, powered_down}, 8'h01, "asleep");
    check(acc, 8'h00, "frozen");
    check(8'(wd_seen - wd0), 8'h01, "watchdog pulse");
    wake = 1'b1;
    wait_ret(t);
    wake = 1'b0;
    check(acc, 8'h5c, "resumed");
    check({7'h00, powered_down}, 8'h00, "awake");
    $display("test halt done");
  endtask

  // whole run is about two hundred clocks, so the limit is generous
  initial begin
    #100000;
    fail_count++;
    final_report();
  end
  initial begin
    reset = 1'b1;
    wake = 1'b0;
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    test_arith();
    test_step_bits();
    test_rotate();
    test_flow();
    test_halt();
    final_report();
  end
endmodule // instruction_timing_and_ops_tb

`default_nettype wire
